// file: hdl/dpc_pkg.sv
/*
  package for the dual-port memory host controller: pin bundles, widths,
  timing counts and the access state codes.
  assumes a 200 MHz clock and that every pin of the memory is sampled
  synchronously to that clock.
*/
package dpc_pkg;
  localparam int ADDR_W = 11;           // 2k words
  localparam int DATA_W = 16;           // two byte lanes
  localparam int BYTE_W = 8;            // one lane
  localparam int CLK_PERIOD_PS = 5000;  // 200 MHz
  // master arbitration time that slave writes must wait out (ns)
  localparam int ARB_DELAY_NS = 45;
  localparam int ARB_DELAY_CYC = (ARB_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write hold after the contention flag rises (ns)
  localparam int WRITE_HOLD_AFTER_FLAG_NS = 30;
  localparam int WRITE_HOLD_AFTER_FLAG_CYC =
    (WRITE_HOLD_AFTER_FLAG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write pulse width and read access time (ns)
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_ACCESS_NS = 90;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;
  localparam logic [1:0] BYTE_ALL = 2'h3;

  // pins driven towards one memory port; controls active low
  typedef struct packed {
    logic select_n;
    logic out_enable_n;
    logic lower_byte_write_n;
    logic upper_byte_write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic [1:0] data_oe;               // per lane, high while we drive
  } dpc_port_pins_t;

  // user request
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;               // bit0 lower, bit1 upper
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpc_req_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_PULSE = 5'h04,
    ST_HOLD  = 5'h08,
    ST_DONE  = 5'h10
  } dpc_state_t;
endpackage

// file: hdl/dpc_timer.sv
/*
  down counter used to time the phases of one memory access.
  assumes load and count are never asked in the same cycle for different
  purposes; load wins.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [dpc_pkg::CNT_W-1:0] load_value,
  output logic expired
);
  import dpc_pkg::*;
  logic [CNT_W-1:0] count; // remaining cycles

  // count down to zero, freeze when clock enable is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= load_value;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  // expired looks at the count alone: the caller decides its load from
  // expired, so gating it with load would close a combinational loop
  assign expired = (count == '0);
endmodule // dpc_timer
`default_nettype wire

// file: hdl/dpc_host.sv
/*
  host controller for one port of a two-port 16-bit static memory,
  master or slave variant. it runs one read or write per request and
  watches the port's active-low contention flag.
  assumes the flag pin is pulled up outside and sampled synchronously.
*/
// How it works
// (RULE1) memory reads and writes port-independently
// (RULE2) high select floats lanes, standby
// (RULE3) both write controls low store word
// (RULE4) lower write only: upper lane output
// (RULE5) upper write only: lower lane output
// (RULE6) read drives both lanes with output enable
// (RULE7) output enable high keeps lanes floating
// (RULE8) master flags only same-address both-selected
// (RULE9) later port gets the contention flag
// (RULE10) never both flags low together
// (RULE11) master discards writes on flagged port
// (RULE12) slave flag pin inhibits writes only
// (RULE13) hold slave flag inputs high normally
// (RULE14) contention flags open-drain, pulled up outside
// (RULE15) single master arbitrates a wide array
// (RULE16) delay slave write by arbitration time
// (RULE17) hold write strobe after flag rises
// (RULE18) flagged reads invalid; stall until released
// (RULE19) write only while select and strobe low
// (RULE20) port resumes by itself after release
`timescale 1ns/1ps
`default_nettype none
module dpc_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire dpc_pkg::dpc_req_t req,
  input wire logic write_inhibit,
  output logic req_ready,
  output logic rsp_valid,
  output logic [dpc_pkg::DATA_W-1:0] rsp_rdata,
  output logic contention_seen,
  output dpc_pkg::dpc_port_pins_t pins,
  output logic flag_out,
  output logic flag_oe,
  input wire logic contention_flag_n,
  input wire logic [dpc_pkg::DATA_W-1:0] data_in
);
  import dpc_pkg::*;

  dpc_state_t state;           // access phase
  dpc_req_t cur;               // latched request
  logic timer_load;            // restart phase timer
  logic [CNT_W-1:0] timer_value;
  logic timer_done;
  logic saw_flag;              // flag was low in the strobe phase of this access

  // low when a lane is being written by this access
  function automatic logic lane_write_n(input logic wr, input logic en);
    lane_write_n = !(wr && en);
  endfunction

  dpc_timer u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_done)
  );

  // phase timer load: setup covers the master's arbitration time so a
  // slave inhibit has settled before the strobe falls
  always_comb begin
    timer_load = 1'b0;
    timer_value = '0;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          timer_load = 1'b1;
          timer_value = CNT_W'(ARB_DELAY_CYC); // RULE16
        end
      end
      ST_SETUP: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_value = cur.write ? CNT_W'(WRITE_PULSE_CYC) : CNT_W'(READ_ACCESS_CYC);
        end
      end
      ST_PULSE: begin
        // a low flag stalls the phase; rising flag starts the hold
        if (!contention_flag_n) begin
          timer_load = 1'b1;
          timer_value = CNT_W'(WRITE_HOLD_AFTER_FLAG_CYC); // RULE17
        end
      end
      default: begin
        timer_load = 1'b0;
      end
    endcase
  end

  // access sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cur <= '0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            cur <= req;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // stay while flag low; finish once the loaded time elapses high (the hold time if the flag was low)
          if (contention_flag_n && timer_done) begin // RULE18
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // contention record for the current access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saw_flag <= 1'b0;
    end else if (ce) begin
      if (state == ST_IDLE) begin
        saw_flag <= 1'b0;
      end else if (state == ST_PULSE && !contention_flag_n) begin
        saw_flag <= 1'b1; // RULE18
      end
    end
  end

  // memory pins; select falls first, the strobes fall after the setup for the write pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '{select_n: 1'b1, out_enable_n: 1'b1, lower_byte_write_n: 1'b1,
                upper_byte_write_n: 1'b1, addr: '0, data_out: '0, data_oe: 2'h0}; // RULE2
    end else if (ce) begin
      if ((state == ST_IDLE && req_valid) || state == ST_SETUP) begin
        // address and select settle first, strobes stay high
        pins.addr <= (state == ST_IDLE) ? req.addr : cur.addr;
        pins.select_n <= 1'b0;
        pins.lower_byte_write_n <= 1'b1;
        pins.upper_byte_write_n <= 1'b1;
        pins.out_enable_n <= 1'b1; // RULE7
        pins.data_oe <= 2'h0;
        if (state == ST_SETUP && timer_done) begin
          // enter the strobe phase on the next edge
          pins.lower_byte_write_n <= lane_write_n(cur.write, cur.byte_en[0]); // RULE19
          pins.upper_byte_write_n <= lane_write_n(cur.write, cur.byte_en[1]); // RULE19
          // unwritten lanes are read back for a read or a partial write, not a full write
          pins.out_enable_n <= cur.write && (cur.byte_en == BYTE_ALL); // RULE3
          pins.data_out <= cur.wdata;
          pins.data_oe <= cur.write ? cur.byte_en : 2'h0; // RULE4 RULE5
        end
      end else if (state == ST_PULSE && contention_flag_n && timer_done) begin
        // end of access: strobes rise, lanes released, port deselected
        pins.lower_byte_write_n <= 1'b1;
        pins.upper_byte_write_n <= 1'b1;
        pins.out_enable_n <= 1'b1;
        pins.data_oe <= 2'h0;
        pins.select_n <= 1'b1; // RULE2
      end
    end
  end

  // wide-array slave: forward the master's flag, never arbitrate here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_oe <= 1'b0;
      flag_out <= 1'b0;
    end else if (ce) begin
      flag_out <= 1'b0; // RULE14
      flag_oe <= write_inhibit; // RULE13 RULE12 RULE15
    end
  end

  // user side answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      contention_seen <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (state == ST_IDLE && req_valid) begin
        req_ready <= 1'b0;
      end
      if (state == ST_PULSE && contention_flag_n && timer_done) begin
        // sample read lanes as the access ends, after the flag released
        rsp_rdata <= data_in; // RULE6 RULE20
        rsp_valid <= 1'b1;
        contention_seen <= saw_flag;
      end
      if (state == ST_DONE) begin
        req_ready <= 1'b1;
      end
    end
  end
endmodule // dpc_host
`default_nettype wire

// file: testbench/dpc_host_props.sv
/*
  assertions on the host handshake and memory port pins.
  assumes one clock domain, reset asynchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_host_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic write_inhibit,
  input wire logic flag_out,
  input wire logic flag_oe,
  input wire logic contention_flag_n,
  input wire dpc_pkg::dpc_port_pins_t pins
);
  import dpc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // an access opens with select; strobes must wait out the setup first
  sequence s_opened; $fell(pins.select_n); endsequence
  sequence s_setup; (pins.lower_byte_write_n && pins.upper_byte_write_n) [*8]; endsequence
  a_take_select: assert property (req_valid && req_ready && ce |=> !pins.select_n)
    else $error("request taken without selecting the port");
  a_setup_wait: assert property (s_opened |-> s_setup)
    else $error("write strobe before setup elapsed");
  a_strobe_select: assert property (!pins.lower_byte_write_n |-> !pins.select_n)
    else $error("write strobe without select");
  a_lane_clash: assert property (!pins.out_enable_n |-> pins.data_oe != 2'h3)
    else $error("output enable while driving both lanes");
  a_flag_stall: assert property (
    (!contention_flag_n && !pins.lower_byte_write_n) [*3] |=> !pins.lower_byte_write_n)
    else $error("strobe released while flag low");
  a_hold_after: assert property (
    $rose(contention_flag_n) && !pins.lower_byte_write_n |=> (!pins.lower_byte_write_n) [*5])
    else $error("write hold after flag too short");
  a_ready_after: assert property (rsp_valid |-> !req_ready ##1 req_ready)
    else $error("port not ready after answer");
  a_open_drain: assert property (!flag_out && flag_oe == $past(write_inhibit))
    else $error("flag drive not open drain");
  a_release_end: assert property (rsp_valid |-> pins.select_n && pins.lower_byte_write_n)
    else $error("port still selected at answer");
endmodule // dpc_host_props
bind dpc_host dpc_host_props u_dpc_host_props (.clk, .rst, .ce, .req_valid, .req_ready,
  .rsp_valid, .write_inhibit, .flag_out, .flag_oe, .contention_flag_n, .pins);
`default_nettype wire

// file: testbench/dpc_mem_model.sv
/*
  one port of the two-port memory, seen from the host under test.
  assumes pins settle on clk and flag_n is the wired contention level.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_mem_model (
  input wire logic clk,
  input wire dpc_pkg::dpc_port_pins_t pins,
  input wire logic flag_n,
  output logic [dpc_pkg::DATA_W-1:0] lanes
);
  import dpc_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // word array, any address
  logic [DATA_W-1:0] last = '0; // floating lanes show its inverse, never a stale copy
  logic [1:0] drv; // lanes the memory drives
  assign drv = {2{!pins.select_n && !pins.out_enable_n}} &
    {pins.upper_byte_write_n, pins.lower_byte_write_n};
  // wire level per lane: host drive, memory drive, or floating
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pins.data_oe[i]) lanes[i*8+:8] = pins.data_out[i*8+:8];
      else if (drv[i]) lanes[i*8+:8] = mem[pins.addr][i*8+:8];
      else lanes[i*8+:8] = ~last[i*8+:8];
    end
  end
  // byte writes gated by a low flag
  always @(posedge clk) begin
    if (!pins.select_n && flag_n) begin
      if (!pins.lower_byte_write_n) mem[pins.addr][7:0] <= lanes[7:0];
      if (!pins.upper_byte_write_n) mem[pins.addr][15:8] <= lanes[15:8];
    end
    last <= lanes;
  end
endmodule // dpc_mem_model
`default_nettype wire

// file: testbench/tb.sv
/*
  self-checking bench: host controller against the memory model.
  assumes the flag line is pulled up and the far port's arbiter is busy_n.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpc_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, write_inhibit = 0, busy_n = 1;
  dpc_req_t req = '0;
  logic req_ready, rsp_valid, contention_seen, flag_out, flag_oe, flag_n;
  logic [DATA_W-1:0] rsp_rdata, data_in, shadow [int];
  dpc_port_pins_t pins;
  logic [17:0] exp_q [$], e; // notes: {read, contention, data}
  int failures = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  // wired flag: pull-up, our open drain and the far arbiter
  assign flag_n = !(flag_oe && !flag_out) && busy_n;
  dpc_host u_dpc_host (.clk, .rst, .ce(1'b1), .req_valid, .req, .write_inhibit, .req_ready,
    .rsp_valid, .rsp_rdata, .contention_seen, .pins, .flag_out, .flag_oe,
    .contention_flag_n(flag_n), .data_in);
  dpc_mem_model u_dpc_mem_model (.clk, .pins, .flag_n, .lanes(data_in));
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // wait until the port is idle again, so a scenario starts on a clean access
  task automatic wait_idle;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask
  // one request; note the expectation, then hand it over when ready
  task automatic access(input logic wr, input logic [1:0] be, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic cont);
    int n;
    exp_q.push_back({!wr, cont, wr ? 16'h0 : shadow[a]});
    if (wr) shadow[a] = {be[1] ? d[15:8] : shadow[a][15:8], be[0] ? d[7:0] : shadow[a][7:0]};
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    req_valid = 1;
    req = '{wr, be, a, d};
    @(posedge clk);
    #1 req_valid = 0;
  endtask
  // compare each answer with the oldest note
  always @(posedge clk) begin
    #1;
    if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      check({15'h0, contention_seen}, {15'h0, e[16]});
      if (e[17]) check(rsp_rdata, e[15:0]);
    end
  end
  initial begin
    logic [ADDR_W-1:0] a;
    int i;
    void'($urandom(32'he7ee5561));
    repeat (16) @(posedge clk);
    #1 rst = 0;
    for (i = 0; i < 8; i++) begin
      a = (i == 7) ? '1 : ADDR_W'($urandom);
      access(1, 2'h3, a, DATA_W'($urandom), 0);
      access(1, i[0] ? 2'h2 : 2'h1, a, DATA_W'($urandom), 0);
      access(0, 2'h3, a, 16'h0, 0);
    end
    // far port holds the flag: write waits, then completes; read stalls
    // the far flag starts two cycles after the request is taken, during setup, so it lands on this access alone
    for (i = 0; i < 2; i++) begin
      wait_idle();
      fork
        access(i == 0, 2'h3, a, 16'ha5c3, 1);
        begin
          repeat (3) @(posedge clk);
          #1 busy_n = 0;
          repeat (30) @(posedge clk);
          #1 busy_n = 1;
        end
      join
    end
    // lock the port through our own flag drive while idle, far flag released
    wait_idle();
    write_inhibit = 1;
    repeat (3) @(posedge clk);
    #1 check({15'h0, flag_n}, 16'h0);
    // a write under the lock waits, then lands once the lock is lifted
    fork
      access(1, 2'h3, a, 16'h3c5a, 1);
      begin
        repeat (20) @(posedge clk);
        #1 write_inhibit = 0;
      end
    join
    access(0, 2'h3, a, 16'h0, 0);
    i = 0;
    while (exp_q.size() > 0 && i < 500) begin
      @(posedge clk);
      i++;
    end
    check(16'(exp_q.size()), 16'h0);
    finish_test;
  end
  // hang guard, well beyond the expected run length
  initial begin
    #200000;
    failures++;
    finish_test;
  end
endmodule // tb
`default_nettype wire
